// ---- mgdm_chk_assertions.sv ----
// Purpose: port checker for the data-move decoder
// Assumes: one clock, nrst asynchronous active low
// Notes: pointer steps are recomputed here from the code bits
`timescale 1ns/10ps
module mgdm_chk (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Instruction port
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire instr_ready,
  input wire instr_done,
  input wire bad_opcode,
  // Strides
  input wire [15:0] first_stride,
  input wire [15:0] second_stride,
  // RAM side and state
  input wire [15:0] ram_addr,
  input wire [15:0] ram_wdata,
  input wire ram_rd_en,
  input wire ram_wr_en,
  input wire [31:0] mcand_b,
  input wire [3:0] flags,
  input wire [63:0] ptr_all
);
  wire [4:0] op = instr_word[15:11]; // Opcode field
  wire [1:0] cd = instr_word[1:0]; // Modification code
  wire [1:0] ps = instr_word[3:2]; // Pointer select
  wire take = instr_valid && instr_ready; // Accepted this edge
  wire unk = op != 5'h17 && op != 5'h14 && op != 5'h15;
  wire f_y = instr_word[8:5] == 4'hC; // Function that copies y
  wire [15:0] sel_ptr = ptr_all[ps*16 +: 16];
  wire [15:0] sel_y = instr_word[4] ? mcand_b[31:16] : mcand_b[15:0];
  // First step doubles as the single step of load and store
  wire [15:0] mid_ptr = sel_ptr + (cd == 2'h3 ? first_stride :
    cd == 2'h2 ? 16'hFFFF : {15'h0, cd[0]});
  wire [15:0] end_ptr = mid_ptr + (cd == 2'h3 ? second_stride :
    cd == 2'h2 ? 16'h2 : {15'h0, ~cd[0]});
  // Pointer n out of a packed vector; the vector is an argument so
  // that the assertion sees its sampled value, not the updated one
  function [15:0] ptr_of(input [63:0] v, input [1:0] n);
    ptr_of = v[n*16 +: 16];
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence ld_take; take && op == 5'h17; endsequence
  sequence st_take; take && op == 5'h14; endsequence
  sequence sw_take; take && op == 5'h15; endsequence
  sequence sw_read; ram_rd_en && !instr_ready; endsequence
  ld_read_a:
    assert property (ld_take |=> ram_rd_en && ram_addr == $past(sel_ptr))
    else $error("load read address wrong");
  ld_done_a:
    assert property (ld_take |-> ##2 instr_done)
    else $error("load not done in time");
  ptr_step_a:
    assert property (ld_take |=>
      ptr_of(ptr_all, $past(ps)) == $past(mid_ptr))
    else $error("pointer step wrong");
  st_write_a:
    assert property (st_take |=> ram_wr_en && ram_addr == $past(sel_ptr)
      && ram_wdata == $past(sel_y))
    else $error("store write wrong");
  st_done_a:
    assert property (st_take |=> !instr_ready ##1 instr_done && instr_ready)
    else $error("store timing wrong");
  sw_move_a:
    assert property (sw_take |=> sw_read ##0 ram_addr == $past(sel_ptr)
      ##1 ram_wr_en && instr_done && ram_wdata == $past(sel_y, 2)
      && ram_addr == $past(mid_ptr, 2))
    else $error("swap sequence wrong");
  sw_ptr_a:
    assert property (sw_take |-> ##2
      ptr_of(ptr_all, $past(ps, 2)) == $past(end_ptr, 2))
    else $error("swap pointer wrong");
  flag_y_a:
    assert property (ld_take ##0 f_y |=> flags[2] == ($past(mcand_b) == 0)
      && flags[3] == $past(mcand_b[31]))
    else $error("flags wrong");
  bad_op_a:
    assert property (take |=> bad_opcode == $past(unk))
    else $error("unknown opcode answer wrong");
endmodule // mgdm_chk
bind mgdm_core mgdm_chk u_mgdm_chk (.clk(clk), .nrst(nrst),
  .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .instr_done(instr_done),
  .bad_opcode(bad_opcode), .first_stride(first_stride),
  .second_stride(second_stride), .ram_addr(ram_addr),
  .ram_wdata(ram_wdata), .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en),
  .mcand_b(mcand_b), .flags(flags), .ptr_all(ptr_all));

// ---- mgdm_core.v ----
// Purpose: decode and execute three multiply/ALU data-move instructions
// Assumes: RAM read data is valid in the same cycle as address and read
//   strobe; RAM writes on the edge closing a cycle with write strobe high
// Notes: x word and strides come from core logic on the same clock
//
// Behaviour
// - Decode sixteen function codes, product/ALU/logical
// - Source bit: 0 picks a0, 1 picks a1
// - Load target 0 is a1; destination opposite
// - All flags follow the computed arithmetic value
// - Sign-extend multiplicand to 36 bits first
// - Function, then RAM transfer, then pointer update
// - Load reads RAM into target accumulator or low
// - Pointer code top bits choose the pointer
// - Half bit 0 low half, 1 whole
// - Post-modify none, +1, -1 or +first stride
// - Load takes one cycle; fixed field layout
// - Store writes multiplicand to RAM, two cycles
// - Swap: save, load, modify, write saved, modify
// - Compound code top bits choose the pointer
// - Paired steps: 0/+1, +1/0, -1/+2, strides
// - Swap is one word, two cycles
`timescale 1ns/10ps
`include "mgdm_defs.vh"

module mgdm_core (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Instruction handshake
  input wire instr_valid,
  input wire [15:0] instr_word,
  output reg instr_ready,
  output reg instr_done,
  output reg bad_opcode,
  // Operands from the core
  input wire [15:0] x_word,
  input wire [15:0] first_stride,
  input wire [15:0] second_stride,
  // Internal data RAM
  input wire [15:0] ram_rdata,
  output reg [15:0] ram_addr,
  output reg [15:0] ram_wdata,
  output reg ram_rd_en,
  output reg ram_wr_en,
  // Architectural state
  output reg [35:0] acc0,
  output reg [35:0] acc1,
  output reg [31:0] prod,
  output reg [31:0] mcand_b,
  output reg [3:0] flags,
  output wire [63:0] ptr_all
);

  // One-hot sequencer states
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_STORE = 3'h2;
  localparam [2:0] ST_SWAP = 3'h4;

  reg [2:0] state_r; // Sequencer state
  reg ld_pend_r; // Load data arrives this cycle
  reg ld_idx_r; // Accumulator the load fills
  reg ld_half_r; // Load whole word when set
  reg [15:0] temp_r; // Saved multiplicand word for swap
  reg sw_half_r; // Swap whole word when set
  reg [1:0] sw_sel_r; // Swap pointer index
  reg [1:0] sw_mod_r; // Swap modification pair

  // Instruction fields
  wire [4:0] opc = instr_word[`MGDM_OPC_HI:`MGDM_OPC_LO];
  wire acc_bit = instr_word[`MGDM_ACC_BIT];
  wire src_bit = instr_word[`MGDM_SRC_BIT];
  wire [3:0] f1 = instr_word[`MGDM_F1_HI:`MGDM_F1_LO];
  wire half_bit = instr_word[`MGDM_HALF_BIT];
  wire [1:0] psel = instr_word[`MGDM_PSEL_HI:`MGDM_PSEL_LO];
  wire [1:0] pmod = instr_word[`MGDM_PMOD_HI:`MGDM_PMOD_LO];

  wire is_load = (opc == `MGDM_OPC_LOAD);
  wire is_store = (opc == `MGDM_OPC_STORE);
  wire is_swap = (opc == `MGDM_OPC_SWAP);
  wire known = is_load | is_store | is_swap;

  // Accept only when idle; ready is low otherwise
  wire take = instr_valid & instr_ready & state_r[0];
  wire go = take & known;

  // Pointer amount for a single or first step
  function [15:0] amt_first;
    input [1:0] code;
    input [15:0] stride;
    begin
      case (code)
        `MGDM_PM_NONE: amt_first = 16'h0000;
        `MGDM_PM_INC: amt_first = 16'h0001;
        `MGDM_PM_DEC: amt_first = 16'hFFFF;
        default: amt_first = stride;
      endcase
    end
  endfunction

  // Pointer amount for the swap's second step
  function [15:0] amt_second;
    input [1:0] code;
    input [15:0] stride;
    begin
      case (code)
        `MGDM_PM_NONE: amt_second = 16'h0001;
        `MGDM_PM_INC: amt_second = 16'h0000;
        `MGDM_PM_DEC: amt_second = 16'h0002;
        default: amt_second = stride;
      endcase
    end
  endfunction

  // Pointer write port, one per cycle at most
  reg ptr_we;
  reg [1:0] ptr_sel;
  reg [15:0] ptr_amt;
  wire [15:0] ptr_cur = ptr_all[{ptr_sel, 4'h0} +: 16];
  // Adds wrap naturally at 16 bits
  wire [15:0] ptr_new = ptr_cur + ptr_amt;

  // Select which pointer moves and by how much
  always @* begin
    ptr_we = 1'b0;
    ptr_sel = psel;
    ptr_amt = 16'h0000;
    if (state_r[2]) begin
      // Second step lands as the saved word's write is set up, one edge before RAM takes it
      ptr_we = 1'b1;
      ptr_sel = sw_sel_r;
      ptr_amt = amt_second(sw_mod_r, second_stride);
    end else if (go) begin
      ptr_we = 1'b1;
      ptr_amt = is_swap ? amt_first(pmod, first_stride)
                        : amt_first(pmod, first_stride);
    end
  end

  // Four pointer registers, updated after their access
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ptr
      reg [15:0] val_r;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          val_r <= `MGDM_WORD_RST;
        end else if (ptr_we && ptr_sel == g) begin
          val_r <= ptr_new;
        end
      end
      assign ptr_all[16*g +: 16] = val_r;
    end
  endgenerate

  // Accumulators with a landing load merged in, so a
  // following function sees the loaded value
  wire [35:0] ld_word = ld_half_r
    ? {{4{ram_rdata[15]}}, ram_rdata, 16'h0000}
    : {(ld_idx_r ? acc1[35:16] : acc0[35:16]), ram_rdata};
  wire [35:0] a0_cur = (ld_pend_r && !ld_idx_r) ? ld_word : acc0;
  wire [35:0] a1_cur = (ld_pend_r && ld_idx_r) ? ld_word : acc1;

  // Operands; 36-bit sign extension of product and multiplicand
  wire [35:0] src = src_bit ? a1_cur : a0_cur;
  wire [35:0] y_ext = {{4{mcand_b[31]}}, mcand_b};
  wire [35:0] p_ext = {{4{prod[31]}}, prod};
  wire [35:0] opb = f1[3] ? y_ext : p_ext;
  wire signed [31:0] mul = $signed(x_word) * $signed(mcand_b[31:16]);

  // Add and subtract at 37 bits to see overflow
  wire [36:0] sum = {src[35], src} + {opb[35], opb};
  wire [36:0] dif = {src[35], src} - {opb[35], opb};

  reg [36:0] res; // Function result, top bit is spare sign
  reg res_wr; // Result goes to destination
  reg res_fl; // Result updates the flags

  // Function decode
  always @* begin
    res = 37'h0;
    res_wr = 1'b1;
    res_fl = 1'b1;
    if (!f1[3]) begin
      // Product group; bit 2 clear also forms a new product
      case (f1[1:0])
        2'h0: res = {opb[35], opb};
        2'h1: res = sum;
        2'h2: begin
          // Product only, or no-op: nothing computed
          res_wr = 1'b0;
          res_fl = 1'b0;
        end
        default: res = dif;
      endcase
    end else begin
      case (f1[2:0])
        3'h0: res = {1'b0, src | opb};
        3'h1: res = {1'b0, src ^ opb};
        3'h2: begin
          res = {1'b0, src & opb};
          res_wr = 1'b0;
        end
        3'h3: begin
          res = dif;
          res_wr = 1'b0;
        end
        3'h4: res = {opb[35], opb};
        3'h5: res = sum;
        3'h6: res = {1'b0, src & opb};
        default: res = dif;
      endcase
    end
  end

  // Flags from the computed value
  wire ov36 = res[36] ^ res[35];
  wire ov32 = ~((res[35:31] == 5'h00) | (res[35:31] == 5'h1F));
  wire [3:0] fl_nxt = {res[35], (res[35:0] == 36'h0), ov36, ov32};

  // Destination is always the accumulator named by bit 10,
  // which for a load is the opposite of the load target
  wire wr0 = go & res_wr & !acc_bit;
  wire wr1 = go & res_wr & acc_bit;

  // Arithmetic state update
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc0 <= `MGDM_ACC_RST;
      acc1 <= `MGDM_ACC_RST;
      prod <= `MGDM_PROD_RST;
      flags <= `MGDM_FLAG_RST;
    end else begin
      // Load data and the next instruction's function result land together; if both
      // name one accumulator, the function result wins
      acc0 <= wr0 ? res[35:0] : a0_cur;
      acc1 <= wr1 ? res[35:0] : a1_cur;
      if (go && !f1[2] && !f1[3]) begin
        prod <= mul;
      end
      if (go && res_fl) begin
        flags <= fl_nxt;
      end
    end
  end

  // Multiplicand register: swap loads it from RAM
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcand_b <= {`MGDM_WORD_RST, `MGDM_WORD_RST};
    end else if (state_r[2]) begin
      if (sw_half_r) begin
        mcand_b <= {ram_rdata, 16'h0000};
      end else begin
        mcand_b <= {mcand_b[31:16], ram_rdata};
      end
    end
  end

  // Sequencer, RAM strobes and handshake
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      instr_ready <= 1'b0;
      instr_done <= 1'b0;
      bad_opcode <= 1'b0;
      ram_addr <= `MGDM_WORD_RST;
      ram_wdata <= `MGDM_WORD_RST;
      ram_rd_en <= 1'b0;
      ram_wr_en <= 1'b0;
      ld_pend_r <= 1'b0;
      ld_idx_r <= 1'b0;
      ld_half_r <= 1'b0;
      temp_r <= `MGDM_WORD_RST;
      sw_half_r <= 1'b0;
      sw_sel_r <= 2'h0;
      sw_mod_r <= 2'h0;
    end else begin
      // Strobes default low; done follows a landing load, bad opcode an unknown take
      ram_rd_en <= 1'b0;
      ram_wr_en <= 1'b0;
      bad_opcode <= take & ~known;
      instr_done <= ld_pend_r;
      ld_pend_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          instr_ready <= 1'b1;
          if (go) begin
            // Address uses the pointer before its update
            ram_addr <= ptr_cur;
            if (is_load) begin
              // Data lands next cycle; a new instruction may
              // be taken then, so a load costs one cycle
              ram_rd_en <= 1'b1;
              ld_pend_r <= 1'b1;
              ld_idx_r <= ~acc_bit;
              ld_half_r <= half_bit;
            end else if (is_store) begin
              ram_wr_en <= 1'b1;
              ram_wdata <= half_bit ? mcand_b[31:16]
                                    : mcand_b[15:0];
              instr_ready <= 1'b0;
              state_r <= ST_STORE;
            end else begin
              // Save the old word before RAM overwrites it
              temp_r <= half_bit ? mcand_b[31:16]
                                 : mcand_b[15:0];
              ram_rd_en <= 1'b1;
              sw_half_r <= half_bit;
              sw_sel_r <= psel;
              sw_mod_r <= pmod;
              instr_ready <= 1'b0;
              state_r <= ST_SWAP;
            end
          end
        end
        ST_STORE: begin
          // Second cycle of the store
          instr_ready <= 1'b1;
          instr_done <= 1'b1;
          state_r <= ST_IDLE;
        end
        ST_SWAP: begin
          // Pointer already holds the first step
          ram_addr <= ptr_cur;
          ram_wdata <= temp_r;
          ram_wr_en <= 1'b1;
          instr_ready <= 1'b1;
          instr_done <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          // Unreachable codes fall back to idle
          instr_ready <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // mgdm_core

// ---- mgdm_defs.vh ----
// Purpose: shared constants for the multiply/ALU data-move decoder
// Assumes: 16-bit instruction words, 16-bit RAM words and pointers
// Notes: definitions only, no logic
`ifndef MGDM_DEFS_VH
`define MGDM_DEFS_VH

// Opcode values, bits 15..11
`define MGDM_OPC_LOAD 5'h17
`define MGDM_OPC_STORE 5'h14
`define MGDM_OPC_SWAP 5'h15

// Field positions
`define MGDM_OPC_HI 15
`define MGDM_OPC_LO 11
`define MGDM_ACC_BIT 10
`define MGDM_SRC_BIT 9
`define MGDM_F1_HI 8
`define MGDM_F1_LO 5
`define MGDM_HALF_BIT 4
`define MGDM_PSEL_HI 3
`define MGDM_PSEL_LO 2
`define MGDM_PMOD_HI 1
`define MGDM_PMOD_LO 0

// Pointer modification codes
`define MGDM_PM_NONE 2'h0
`define MGDM_PM_INC 2'h1
`define MGDM_PM_DEC 2'h2
`define MGDM_PM_STR 2'h3

// Function codes that neither write nor flag
`define MGDM_F1_PONLY 4'h2
`define MGDM_F1_NOP 4'h6
// Test-only codes: flags but no write
`define MGDM_F1_ANDT 4'hA
`define MGDM_F1_SUBT 4'hB

// Reset values
`define MGDM_ACC_RST 36'h0
`define MGDM_WORD_RST 16'h0
`define MGDM_PROD_RST 32'h0
`define MGDM_FLAG_RST 4'h0

// Flag bit positions
`define MGDM_FL_NEG 3
`define MGDM_FL_ZERO 2
`define MGDM_FL_OV36 1
`define MGDM_FL_OV32 0

`endif

// ---- mgdm_ram.sv ----
// Purpose: behavioural internal data RAM facing the decoder
// Assumes: read data valid while the read strobe stands
// Notes: idle cycles show a toggling pattern, never stale data
`timescale 1ns/10ps
module mgdm_ram (
  // Clock
  input wire clk,
  // Access from the decoder
  input wire [15:0] ram_addr,
  input wire [15:0] ram_wdata,
  input wire ram_rd_en,
  input wire ram_wr_en,
  // Read data
  output wire [15:0] ram_rdata
);
  logic [15:0] mem_r [0:65535]; // Full word space
  logic [15:0] junk_r = 16'h5A5A; // Pattern outside reads
  assign ram_rdata = ram_rd_en ? mem_r[ram_addr] : junk_r;
  // Write lands on the edge closing the strobe cycle
  always @(posedge clk) begin
    junk_r <= ~junk_r;
    if (ram_wr_en)
      mem_r[ram_addr] <= ram_wdata;
  end
endmodule // mgdm_ram

// ---- test_mgdm_core.sv ----
// Purpose: self-checking bench for the data-move decoder
// Assumes: RAM model answers reads in the same cycle
// Notes: expectations are tracked here, not read back
`timescale 1ns/10ps
module test_mgdm_core;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0;
  logic [15:0] x_word = 16'h0003;
  logic [15:0] first_stride = 16'h0010;
  logic [15:0] second_stride = 16'h0100;
  wire instr_ready, instr_done, bad_opcode, ram_rd_en, ram_wr_en;
  wire [15:0] ram_rdata, ram_addr, ram_wdata;
  wire [35:0] acc0, acc1;
  wire [31:0] mcand_b;
  wire [31:0] prod;
  logic [31:0] ep; // Expected product, kept at 32 bits
  wire [3:0] flags;
  wire [63:0] ptr_all;
  int mismatches = 0;
  int tests_run = 0;
  logic [15:0] ty, tp, rd, wa; // Tracked y, pointer 3, read, write address
  logic [35:0] e36; // Expected accumulator
  mgdm_core u_mgdm_core (.clk(clk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready),
    .instr_done(instr_done), .bad_opcode(bad_opcode), .x_word(x_word),
    .first_stride(first_stride), .second_stride(second_stride),
    .ram_rdata(ram_rdata), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en), .acc0(acc0), .acc1(acc1),
    .prod(prod), .mcand_b(mcand_b), .flags(flags), .ptr_all(ptr_all));
  mgdm_ram u_mgdm_ram (.clk(clk), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en),
    .ram_rdata(ram_rdata));
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Offer one word; answer strobe is sampled at its due edge
  task run(input logic [15:0] w, input int lat);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
    chk("ready", instr_ready, 1'b1);
    instr_valid <= 1'b0;
    repeat (lat) @(posedge clk);
    chk("answer", lat == 2 ? instr_done : bad_opcode, 1'b1);
  endtask
  task t_swap;
    ty = 16'h0;
    tp = 16'h0;
    for (int c = 0; c < 4; c++) begin
      rd = u_mgdm_ram.mem_r[tp];
      wa = tp + (c == 3 ? first_stride : c == 2 ? 16'hFFFF : c[15:0]);
      run({5'h15, 2'h0, 4'h6, 1'b1, 2'h3, c[1:0]}, 2);
      @(posedge clk);
      chk("swap y", mcand_b[31:16], rd);
      chk("swap ram", u_mgdm_ram.mem_r[wa], ty);
      tp = wa + (c == 3 ? second_stride : c == 2 ? 16'h2 : {15'h0, ~c[0]});
      chk("swap ptr", ptr_all[63:48], tp);
      ty = rd;
    end
  endtask
  task t_store;
    e36 = {{4{ty[15]}}, ty, 16'h0};
    run({5'h14, 2'h0, 4'hC, 1'b1, 2'h2, 2'h2}, 2);
    chk("st acc0", acc0, e36);
    chk("st neg", flags[3], ty[15]);
    run({5'h14, 2'h0, 4'h6, 1'b0, 2'h2, 2'h1}, 2);
    @(posedge clk);
    chk("st ram", u_mgdm_ram.mem_r[0], ty);
    chk("st low", u_mgdm_ram.mem_r[16'hFFFF], 16'h0);
    chk("st ptr", ptr_all[47:32], 16'h0);
  endtask
  task t_load;
    run({5'h17, 2'h1, 4'hF, 1'b1, 2'h0, 2'h3}, 2);
    chk("ld acc1", acc1, e36);
    e36 = -e36;
    chk("ld sub", acc0, e36);
    run({5'h17, 2'h2, 4'h6, 1'b0, 2'h0, 2'h2}, 2);
    chk("ld low", acc0, {e36[35:16], first_stride ^ 16'h8C3C});
    chk("ld ptr", ptr_all[15:0], first_stride - 16'h1);
  endtask
  task t_bad;
    run(16'h0000, 1);
    chk("bad ptr", ptr_all[63:48], tp);
    for (int f = 0; f < 16; f++)
      run({5'h17, 2'h0, f[3:0], 1'b1, 2'h1, 2'h0}, 2);
    // Product of x and the multiplicand high half, signed
    ep = $signed(x_word) * $signed(ty);
    chk("prod", prod, ep);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // 4 ns clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Hang guard, far beyond the some 120 cycles needed
  initial begin
    #20000;
    mismatches++;
    close_out;
  end
  initial begin
    for (int i = 0; i < 65536; i++)
      u_mgdm_ram.mem_r[i] = i[15:0] ^ 16'h8C3C;
    repeat (10) @(posedge clk);
    chk("rst ready", instr_ready, 1'b0);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rst ptr", ptr_all, 64'h0);
    t_swap;
    t_store;
    t_load;
    t_bad;
    close_out;
  end
endmodule // test_mgdm_core
